// File: logic/umi_map.svh
// Operation
// - frame: start, chars, marker, parity, stops
// - parity after marker, marker in parity
// - LSB first, format from serial mode
// - sent marker from marker select bit
// - powered multiproc idle line drives high
// - buffer write starts frame when enabled
// - framing bits added by hardware
// - buffer to shifter, chain or idle
// - late marker change may hit waiting data
// - receiver waits start, samples at rate
// - address frame: irq, buffer, address flag
// - filter cleared drops data frames silently
// - infrared: 7 or 8 bits from char length bit, no parity, 1 stop
// - rate from divider and clock select
// - receive errors readable in status
// - receiver checks only one stop bit
// - split bit separates error interrupt
`ifndef UMI_MAP_SVH
`define UMI_MAP_SVH
`define UMI_A_MODE      3'h0
`define UMI_A_RXSTAT    3'h1
`define UMI_A_TXSTAT    3'h2
`define UMI_A_BUF       3'h3
`define UMI_A_CLKSEL    3'h4
`define UMI_A_BAUD      3'h5
`define UMI_A_XFER      3'h6
`define UMI_M_POWER     7
`define UMI_M_TXE       6
`define UMI_M_RXE       5
`define UMI_M_PAR_HI    4
`define UMI_M_PAR_LO    3
`define UMI_M_CHAR8     2
`define UMI_M_STOP2     1
`define UMI_M_SPLIT     0
`define UMI_X_IR        7
`define UMI_X_MP        6
`define UMI_X_FILT      1
`define UMI_X_MARK      0
`define UMI_C_PW_HI     3
`define UMI_C_PS_HI     6
`define UMI_C_PS_LO     4
`define UMI_PAR_NONE    2'h0
`define UMI_PAR_ZERO    2'h1
`define UMI_PAR_ODD     2'h2
`define UMI_PAR_EVEN    2'h3
`define UMI_RST_REG     8'h00
`define UMI_MIN_PERIOD  8'h02
`endif

// File: logic/umi_pkg.sv
package umi_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_MARK,
      ST_PAR,
      ST_STOP
   } umi_frame_t;
endpackage : umi_pkg

// File: logic/umi_baud.sv
`timescale 1ns/1ps
// prescaled base tick: one pulse every 2**sel clocks
module umi_baud #(
   parameter int SEL_W = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic             run,
   input  wire logic [SEL_W-1:0] sel,
   output logic                  tick
);
   localparam int CNT_W = (1 << SEL_W) - 1;

   initial begin
      if (SEL_W < 1 || SEL_W > 4) begin
         $error("umi_baud: SEL_W out of range");
      end
   end

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] mask;

   always_comb begin
      mask = '0;
      for (int i = 0; i < CNT_W; i++) begin
         mask[i] = (i < int'(sel));
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (!run) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tick <= 1'b0;
      end else begin
         tick <= run && ((cnt_reg & mask) == mask);
      end
   end
endmodule : umi_baud

// File: logic/umi_top.sv
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`include "umi_map.svh"
module umi_top #(
   parameter int DATA_W = 8
) (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic [7:0]      rd_data,
   input  wire logic       serial_in_pin,
   output logic            serial_out_pin,
   output logic            rx_done_irq,
   output logic            rx_error_irq
);
   initial begin
      if (DATA_W != 8) begin
         $error("umi_top: only 8-bit characters supported");
      end
   end

   logic [7:0] serial_mode_reg;
   logic [7:0] transfer_mode_reg;
   logic [7:0] clock_select_reg;
   logic [7:0] baud_divider_reg;
   logic [7:0] tx_holding_buffer;
   logic [7:0] rx_holding_buffer;
   logic [3:0] rx_status_reg;
   logic       tx_buffer_full_flag;
   logic       rx_full_reg;

   logic       unit_power_bit;
   logic       transmit_enable_bit;
   logic       receive_enable_bit;
   logic       ir_mode;
   logic       mp_mode;
   logic [1:0] par_mode;
   logic [3:0] dlen;
   logic [7:0] period;
   logic [7:0] half;
   logic       tick;
   logic       tx_busy;

   function automatic logic [7:0] bit_period(input logic [7:0] d);
      return (d < `UMI_MIN_PERIOD) ? `UMI_MIN_PERIOD : d;
   endfunction : bit_period

   // parity bit value from running xor of data and marker
   function automatic logic par_bit(input logic [1:0] m, input logic acc);
      unique case (m)
         `UMI_PAR_ODD:  return ~acc;
         `UMI_PAR_EVEN: return acc;
         default:       return 1'b0;
      endcase
   endfunction : par_bit

   assign unit_power_bit      = serial_mode_reg[`UMI_M_POWER];
   assign transmit_enable_bit = serial_mode_reg[`UMI_M_TXE];
   assign receive_enable_bit  = serial_mode_reg[`UMI_M_RXE];
   assign ir_mode             = transfer_mode_reg[`UMI_X_IR];
   assign mp_mode             = transfer_mode_reg[`UMI_X_MP] && !ir_mode;
   assign par_mode            = serial_mode_reg[`UMI_M_PAR_HI:`UMI_M_PAR_LO];
   assign dlen   = serial_mode_reg[`UMI_M_CHAR8] ? 4'h8 : 4'h7;
   assign period = bit_period(baud_divider_reg);
   assign half   = {1'b0, period[7:1]};

   umi_baud #(
      .SEL_W (3)
   ) u_baud (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .run     (unit_power_bit),
      .sel     (clock_select_reg[`UMI_C_PS_HI:`UMI_C_PS_LO]),
      .tick    (tick)
   );

   // ---------------- register writes and reads
   logic wr_buf;
   logic rd_buf;
   assign wr_buf = wr_en && (addr == `UMI_A_BUF);
   assign rd_buf = rd_en && (addr == `UMI_A_BUF);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serial_mode_reg   <= `UMI_RST_REG;
         transfer_mode_reg <= `UMI_RST_REG;
         clock_select_reg  <= `UMI_RST_REG;
         baud_divider_reg  <= `UMI_RST_REG;
      end else if (wr_en) begin
         unique case (addr)
            `UMI_A_MODE:   serial_mode_reg   <= wr_data;
            `UMI_A_XFER:   transfer_mode_reg <= wr_data;
            `UMI_A_CLKSEL: clock_select_reg  <= wr_data;
            `UMI_A_BAUD:   baud_divider_reg  <= wr_data;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         unique case (addr)
            `UMI_A_MODE:   rd_data <= serial_mode_reg;
            `UMI_A_RXSTAT: rd_data <= {4'h0, rx_status_reg};
            `UMI_A_TXSTAT: rd_data <= {6'h00, tx_buffer_full_flag, tx_busy};
            `UMI_A_BUF:    rd_data <= rx_holding_buffer;
            `UMI_A_CLKSEL: rd_data <= clock_select_reg;
            `UMI_A_BAUD:   rd_data <= baud_divider_reg;
            `UMI_A_XFER:   rd_data <= transfer_mode_reg;
            default:       rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   // ---------------- transmitter
   umi_pkg::umi_frame_t tx_st;
   logic [7:0] tx_cnt;
   logic [7:0] tx_shifter;
   logic [2:0] tx_idx;
   logic       tx_mark;
   logic       tx_acc;
   logic       tx_stop2;
   logic       tx_on;
   logic       tx_bend;
   logic       tx_free;
   logic       tx_load;
   logic       tx_level;

   assign tx_on   = unit_power_bit && transmit_enable_bit;
   assign tx_busy = (tx_st != umi_pkg::ST_IDLE);
   assign tx_bend = tick && tx_busy && (tx_cnt == period - 8'h01);
   assign tx_free = !tx_busy ||
                    (tx_bend && (tx_st == umi_pkg::ST_STOP) && !tx_stop2);
   assign tx_load = tx_on && tx_buffer_full_flag && tx_free;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tx_holding_buffer   <= '0;
         tx_buffer_full_flag <= 1'b0;
      end else if (wr_buf) begin
         tx_holding_buffer   <= wr_data;
         tx_buffer_full_flag <= 1'b1;
      end else if (tx_load) begin
         tx_buffer_full_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tx_st      <= umi_pkg::ST_IDLE;
         tx_cnt     <= '0;
         tx_shifter <= '0;
         tx_idx     <= '0;
         tx_mark    <= 1'b0;
         tx_acc     <= 1'b0;
         tx_stop2   <= 1'b0;
      end else if (!tx_on) begin
         tx_st  <= umi_pkg::ST_IDLE;
         tx_cnt <= '0;
      end else if (tx_load) begin
         tx_shifter <= tx_holding_buffer;
         tx_mark    <= transfer_mode_reg[`UMI_X_MARK];
         tx_acc     <= 1'b0;
         tx_idx     <= '0;
         tx_cnt     <= '0;
         tx_st      <= umi_pkg::ST_START;
      end else if (tx_bend) begin
         tx_cnt <= '0;
         unique case (tx_st)
            umi_pkg::ST_START: tx_st <= umi_pkg::ST_DATA;
            umi_pkg::ST_DATA: begin
               tx_acc <= tx_acc ^ tx_shifter[tx_idx];
               tx_idx <= tx_idx + 3'h1;
               if ({1'b0, tx_idx} == dlen - 4'h1) begin
                  if (mp_mode) begin
                     tx_st <= umi_pkg::ST_MARK;
                  end else if (par_mode != `UMI_PAR_NONE && !ir_mode) begin
                     tx_st <= umi_pkg::ST_PAR;
                  end else begin
                     tx_st    <= umi_pkg::ST_STOP;
                     tx_stop2 <= serial_mode_reg[`UMI_M_STOP2] && !ir_mode;
                  end
               end
            end
            umi_pkg::ST_MARK: begin
               tx_acc <= tx_acc ^ tx_mark;
               if (par_mode != `UMI_PAR_NONE) begin
                  tx_st <= umi_pkg::ST_PAR;
               end else begin
                  tx_st    <= umi_pkg::ST_STOP;
                  tx_stop2 <= serial_mode_reg[`UMI_M_STOP2];
               end
            end
            umi_pkg::ST_PAR: begin
               tx_st    <= umi_pkg::ST_STOP;
               tx_stop2 <= serial_mode_reg[`UMI_M_STOP2];
            end
            umi_pkg::ST_STOP: begin
               if (tx_stop2) begin
                  tx_stop2 <= 1'b0;
               end else begin
                  tx_st <= umi_pkg::ST_IDLE;
               end
            end
            umi_pkg::ST_IDLE: tx_st <= umi_pkg::ST_IDLE;
         endcase
      end else if (tick && tx_busy) begin
         tx_cnt <= tx_cnt + 8'h01;
      end
   end

   always_comb begin
      unique case (tx_st)
         umi_pkg::ST_START: tx_level = 1'b0;
         umi_pkg::ST_DATA:  tx_level = tx_shifter[tx_idx];
         umi_pkg::ST_MARK:  tx_level = tx_mark;
         umi_pkg::ST_PAR:   tx_level = par_bit(par_mode, tx_acc);
         default:           tx_level = 1'b1;
      endcase
   end

   // short pulse from mid-bit, width in base ticks
   logic ir_window;
   assign ir_window = (tx_cnt >= half) &&
                      (tx_cnt < half + {4'h0, clock_select_reg[`UMI_C_PW_HI:0]});

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         serial_out_pin <= 1'b1;
      end else if (!unit_power_bit) begin
         serial_out_pin <= 1'b1;
      end else if (ir_mode) begin
         serial_out_pin <= tx_busy && !tx_level && ir_window;
      end else begin
         serial_out_pin <= tx_level;
      end
   end

   // ---------------- receiver
   umi_pkg::umi_frame_t rx_st;
   logic [7:0] rx_cnt;
   logic [7:0] rx_shifter;
   logic [2:0] rx_idx;
   logic       rx_mark;
   logic       rx_acc;
   logic       rx_perr;
   logic       rx_on;
   logic       ir_seen;
   logic       rx_val;
   logic       rx_samp;
   logic       rx_end;
   logic       rx_ferr;

   assign rx_on   = unit_power_bit && receive_enable_bit;
   assign rx_val  = ir_mode ? !(ir_seen || serial_in_pin) : serial_in_pin;
   assign rx_samp = tick && (rx_st != umi_pkg::ST_IDLE) &&
                    (rx_cnt == ((rx_st == umi_pkg::ST_START) ?
                                half - 8'h01 : period - 8'h01));
   assign rx_end  = rx_samp && (rx_st == umi_pkg::ST_STOP);
   assign rx_ferr = !rx_val;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ir_seen <= 1'b0;
      end else if (serial_in_pin && ir_mode) begin
         ir_seen <= 1'b1;
      end else if (rx_samp || rx_st == umi_pkg::ST_IDLE) begin
         ir_seen <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rx_st      <= umi_pkg::ST_IDLE;
         rx_cnt     <= '0;
         rx_shifter <= '0;
         rx_idx     <= '0;
         rx_mark    <= 1'b0;
         rx_acc     <= 1'b0;
         rx_perr    <= 1'b0;
      end else if (!rx_on) begin
         rx_st  <= umi_pkg::ST_IDLE;
         rx_cnt <= '0;
      end else if (rx_st == umi_pkg::ST_IDLE) begin
         if (ir_mode ? serial_in_pin : !serial_in_pin) begin
            rx_st      <= umi_pkg::ST_START;
            rx_cnt     <= '0;
            rx_shifter <= '0;
            rx_idx     <= '0;
            rx_mark    <= 1'b0;
            rx_acc     <= 1'b0;
            rx_perr    <= 1'b0;
         end
      end else if (rx_samp) begin
         rx_cnt <= '0;
         unique case (rx_st)
            umi_pkg::ST_START: begin
               rx_st <= rx_val ? umi_pkg::ST_IDLE : umi_pkg::ST_DATA;
            end
            umi_pkg::ST_DATA: begin
               rx_shifter[rx_idx] <= rx_val;
               rx_acc <= rx_acc ^ rx_val;
               rx_idx <= rx_idx + 3'h1;
               if ({1'b0, rx_idx} == dlen - 4'h1) begin
                  if (mp_mode) begin
                     rx_st <= umi_pkg::ST_MARK;
                  end else if (par_mode != `UMI_PAR_NONE && !ir_mode) begin
                     rx_st <= umi_pkg::ST_PAR;
                  end else begin
                     rx_st <= umi_pkg::ST_STOP;
                  end
               end
            end
            umi_pkg::ST_MARK: begin
               rx_mark <= rx_val;
               rx_acc  <= rx_acc ^ rx_val;
               rx_st   <= (par_mode != `UMI_PAR_NONE) ?
                          umi_pkg::ST_PAR : umi_pkg::ST_STOP;
            end
            umi_pkg::ST_PAR: begin
               rx_perr <= (par_mode == `UMI_PAR_ODD || par_mode == `UMI_PAR_EVEN) &&
                          (rx_val != par_bit(par_mode, rx_acc));
               rx_st   <= umi_pkg::ST_STOP;
            end
            default: rx_st <= umi_pkg::ST_IDLE;
         endcase
      end else if (tick) begin
         rx_cnt <= rx_cnt + 8'h01;
      end
   end

   // ---------------- receive completion
   logic rx_accept;
   logic rx_ovr;
   logic rx_err;

   // data frames dropped while filter cleared
   assign rx_accept = rx_end &&
                      !(mp_mode && !transfer_mode_reg[`UMI_X_FILT] && !rx_mark);
   assign rx_ovr    = rx_full_reg;
   assign rx_err    = rx_perr || rx_ferr || rx_ovr;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rx_holding_buffer <= '0;
         rx_status_reg     <= '0;
         rx_full_reg       <= 1'b0;
      end else if (rx_accept) begin
         rx_status_reg <= {mp_mode && rx_mark, rx_perr, rx_ferr, rx_ovr};
         if (!rx_ovr) begin
            rx_holding_buffer <= rx_shifter & (serial_mode_reg[`UMI_M_CHAR8] ?
                                               8'hff : 8'h7f);
            rx_full_reg       <= 1'b1;
         end
      end else if (rd_buf) begin
         rx_status_reg <= '0;
         rx_full_reg   <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rx_done_irq  <= 1'b0;
         rx_error_irq <= 1'b0;
      end else begin
         rx_done_irq  <= rx_accept && !(rx_err && serial_mode_reg[`UMI_M_SPLIT]);
         rx_error_irq <= rx_accept && rx_err && serial_mode_reg[`UMI_M_SPLIT];
      end
   end
endmodule : umi_top

// File: test/umi_props.sv
`timescale 1ns/1ps
module umi_props (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rd_data,
   input wire logic       serial_in_pin,
   input wire logic       serial_out_pin,
   input wire logic       rx_done_irq,
   input wire logic       rx_error_irq
);
   logic pwr_reg;
   logic rxe_reg;
   // shadow of power and receive enable
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pwr_reg <= 1'b0;
         rxe_reg <= 1'b0;
      end else if (wr_en && addr == 3'h0) begin
         pwr_reg <= wr_data[7];
         rxe_reg <= wr_data[5];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   rd_slot_zero_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data outside its slot");
   unmapped_zero_a: assert property (rd_en && addr == 3'h7 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   rxstat_width_a: assert property (rd_en && addr == 3'h1 |=> rd_data[7:4] == 4'h0)
      else $error("rx status spare bits set");
   txstat_width_a: assert property (rd_en && addr == 3'h2 |=> rd_data[7:2] == 6'h00)
      else $error("tx status spare bits set");
   done_pulse_a: assert property (rx_done_irq |=> !rx_done_irq)
      else $error("done pulse too long");
   err_pulse_a: assert property (rx_error_irq |=> !rx_error_irq)
      else $error("error pulse too long");
   irq_exclusive_a: assert property (not (rx_done_irq && rx_error_irq))
      else $error("both receive pulses at once");
   idle_high_a: assert property (!pwr_reg && !$past(pwr_reg) |-> serial_out_pin)
      else $error("line not high while unpowered");
   rx_off_quiet_a: assert property ((!rxe_reg) [*2] |-> !rx_done_irq && !rx_error_irq)
      else $error("receive pulse while disabled");
endmodule : umi_props
bind umi_top umi_props u_umi_props (
   .clk_sys        (clk_sys),
   .nrst           (nrst),
   .addr           (addr),
   .wr_data        (wr_data),
   .wr_en          (wr_en),
   .rd_en          (rd_en),
   .rd_data        (rd_data),
   .serial_in_pin  (serial_in_pin),
   .serial_out_pin (serial_out_pin),
   .rx_done_irq    (rx_done_irq),
   .rx_error_irq   (rx_error_irq)
);

// File: test/umi_peer.sv
`timescale 1ns/1ps
module umi_peer #(
   parameter int PER = 4
) (
   input  wire logic clk_sys,
   input  wire logic serial_out_pin,
   output logic      serial_in_pin
);
   initial serial_in_pin = 1'b1;
   // whole frame lsb first, line idle high
   task automatic send(input logic [15:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         serial_in_pin <= b[i];
         repeat (PER) @(posedge clk_sys);
      end
      serial_in_pin <= 1'b1;
      repeat (2 * PER) @(posedge clk_sys);
   endtask : send
   task automatic catch(input int n, output logic [15:0] b, output logic ok);
      int k;
      b = 16'h0000;
      for (k = 0; k < 400 && serial_out_pin !== 1'b0; k++) @(posedge clk_sys);
      ok = (k < 400);
      repeat (PER / 2) @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         if (i > 0) repeat (PER) @(posedge clk_sys);
         b[i] = serial_out_pin;
      end
   endtask : catch
endmodule : umi_peer

// File: test/tb_top.sv
`timescale 1ns/1ps
`include "umi_map.svh"
module tb_top;
   logic       clk_sys;
   logic       nrst;
   logic [2:0] addr;
   logic [7:0] wr_data;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] rd_data;
   logic       serial_in_pin;
   logic       serial_out_pin;
   logic       rx_done_irq;
   logic       rx_error_irq;
   int         failures;
   int         checks;
   int         n_done;
   int         n_err;
   umi_top u_umi_top (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin), .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq));
   umi_peer u_umi_peer (.clk_sys(clk_sys), .serial_out_pin(serial_out_pin),
      .serial_in_pin(serial_in_pin));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rx_done_irq === 1'b1) n_done++;
      if (rx_error_irq === 1'b1) n_err++;
   end
   task automatic give_verdict();
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 chk(rd_data, e);
   endtask : rdc
   task automatic rdq(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rdq
   function automatic logic [15:0] frame(input logic [7:0] d, input int nch, input logic mp,
      input logic mk, input logic [1:0] par, input int stops, output int n);
      logic [15:0] f;
      logic        x;
      f = 16'hfffe;
      x = mp & mk;
      for (int i = 0; i < nch; i++) begin
         f[1 + i] = d[i];
         x ^= d[i];
      end
      n = 1 + nch;
      if (mp) f[n++] = mk;
      if (par == `UMI_PAR_ODD) f[n] = ~x;
      if (par == `UMI_PAR_EVEN) f[n] = x;
      if (par == `UMI_PAR_ZERO) f[n] = 1'b0;
      n = n + (par != `UMI_PAR_NONE) + stops;
      return f & ((16'h0001 << n) - 16'h0001);
   endfunction : frame
   task automatic t_reset();
      for (int a = 0; a < 8; a++) rdc(a[2:0], 8'h00);
      wr(3'h7, 8'hff);
      wr(`UMI_A_RXSTAT, 8'hff);
      wr(`UMI_A_TXSTAT, 8'hff);
      rdc(`UMI_A_RXSTAT, 8'h00);
      rdc(`UMI_A_TXSTAT, 8'h00);
      rdc(3'h7, 8'h00);
   endtask : t_reset
   task automatic t_tx_fmt();
      logic [7:0]  md[4] = '{8'he4, 8'hf4, 8'hfa, 8'hec};
      logic [7:0]  dt[4] = '{8'h55, 8'h7d, 8'h35, 8'h9b};
      logic [1:0]  pr[4] = '{`UMI_PAR_NONE, `UMI_PAR_ODD, `UMI_PAR_EVEN, `UMI_PAR_ZERO};
      logic [15:0] e;
      logic [15:0] b;
      logic        ok;
      int          n;
      for (int i = 0; i < 4; i++) begin
         wr(`UMI_A_MODE, md[i]);
         wr(`UMI_A_XFER, 8'h42 | 8'(i % 2));
         repeat (3) @(posedge clk_sys);
         chk(serial_out_pin, 1'b1);
         e = frame(dt[i], (i == 2) ? 7 : 8, 1'b1, i[0], pr[i], (i == 2) ? 2 : 1, n);
         fork
            u_umi_peer.catch(n, b, ok);
            wr(`UMI_A_BUF, dt[i]);
         join
         chk(ok, 1'b1);
         chk(b, e);
      end
   endtask : t_tx_fmt
   task automatic t_chain();
      logic [15:0] b1;
      logic [15:0] b2;
      logic        ok1;
      logic        ok2;
      int          n;
      int          k;
      logic [7:0]  s;
      wr(`UMI_A_MODE, 8'hf4);
      wr(`UMI_A_XFER, 8'h43);
      fork
         begin
            u_umi_peer.catch(12, b1, ok1);
            u_umi_peer.catch(12, b2, ok2);
         end
         begin
            wr(`UMI_A_BUF, 8'h55);
            s = 8'h02;
            for (k = 0; k < 50 && s[1] !== 1'b0; k++) begin
               rdq(`UMI_A_TXSTAT, s);
            end
            if (k == 50) begin
               failures++;
               give_verdict();
            end
            wr(`UMI_A_XFER, 8'h42);
            wr(`UMI_A_BUF, 8'ha3);
            rdc(`UMI_A_TXSTAT, 8'h03);
         end
      join
      chk(ok1 & ok2, 1'b1);
      chk(b1, frame(8'h55, 8, 1'b1, 1'b1, `UMI_PAR_ODD, 1, n));
      chk(b2, frame(8'ha3, 8, 1'b1, 1'b0, `UMI_PAR_ODD, 1, n));
   endtask : t_chain
   task automatic rxf(input logic [7:0] d, input logic mk, input logic [15:0] bad,
      input int ed, input int ee, input logic [7:0] st);
      int          n;
      int          d0;
      int          e0;
      logic [15:0] f;
      d0 = n_done;
      e0 = n_err;
      f = frame(d, 8, 1'b1, mk, `UMI_PAR_ODD, 1, n);
      u_umi_peer.send(f ^ bad, n);
      chk(16'(n_done - d0), 16'(ed));
      chk(16'(n_err - e0), 16'(ee));
      rdc(`UMI_A_RXSTAT, st);
   endtask : rxf
   task automatic t_rx();
      wr(`UMI_A_MODE, 8'hf5);
      wr(`UMI_A_XFER, 8'h43);
      rxf(8'h5a, 1'b1, 16'h0000, 1, 0, 8'h08);
      rdc(`UMI_A_BUF, 8'h5a);
      wr(`UMI_A_XFER, 8'h41);
      rxf(8'h33, 1'b0, 16'h0000, 0, 0, 8'h00);
      rxf(8'h11, 1'b1, 16'h0000, 1, 0, 8'h08);
      rdc(`UMI_A_BUF, 8'h11);
      wr(`UMI_A_XFER, 8'h43);
      rxf(8'h22, 1'b0, 16'h0400, 0, 1, 8'h04);
      rdc(`UMI_A_BUF, 8'h22);
      rxf(8'h44, 1'b0, 16'h0800, 0, 1, 8'h02);
      rdc(`UMI_A_BUF, 8'h44);
      rxf(8'h66, 1'b0, 16'h0000, 1, 0, 8'h00);
      rxf(8'h77, 1'b0, 16'h0000, 0, 1, 8'h01);
      rdc(`UMI_A_BUF, 8'h66);
      rdc(`UMI_A_RXSTAT, 8'h00);
      wr(`UMI_A_MODE, 8'hf4);
      rxf(8'h22, 1'b0, 16'h0400, 1, 0, 8'h04);
      rdc(`UMI_A_BUF, 8'h22);
      wr(`UMI_A_MODE, 8'hd4);
      rxf(8'h5a, 1'b1, 16'h0000, 0, 0, 8'h00);
   endtask : t_rx
   task automatic t_ir();
      wr(`UMI_A_MODE, 8'h00);
      wr(`UMI_A_CLKSEL, 8'h02);
      wr(`UMI_A_XFER, 8'h80);
      wr(`UMI_A_MODE, 8'h80);
      repeat (3) @(posedge clk_sys);
      chk(serial_out_pin, 1'b0);
      wr(`UMI_A_MODE, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk(serial_out_pin, 1'b1);
   endtask : t_ir
   initial begin
      nrst = 1'b0;
      addr = 3'h0;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      wr(`UMI_A_CLKSEL, 8'h00);
      wr(`UMI_A_BAUD, 8'h04);
      t_tx_fmt();
      t_chain();
      t_rx();
      t_ir();
      give_verdict();
   end
endmodule : tb_top
